// file: hw/drs_pkg.sv
// Constants for the refresh scheduler of one memory channel.
// Assumes a single memory clock and a synchronous controller reset.
package drs_pkg;
    localparam logic [11:0] REG_OFFSET = 12'h269;
    localparam int REG_W = 48;
    localparam int REG_BYTES = 6;
    localparam logic [47:0] REG_RESET = 48'h021830000c30;
    localparam logic [47:0] REG_WMASK = 48'h03fffbcfffff;
    localparam int DIRQ_LSB = 37;
    localparam int INDQ_LSB = 32;
    localparam int WAIT_LSB = 27;
    localparam int CNTEN_BIT = 25;
    localparam int STYLE_BIT = 24;
    localparam int GATE_BIT = 23;
    localparam int DONE_BIT = 22;
    localparam int PANIC_LSB = 18;
    localparam int HIGH_LSB = 16;
    localparam int LOW_LSB = 14;
    localparam int INTV_LSB = 0;
    localparam int INTV_W = 14;
    localparam int WIN_W = 5;
    localparam int OWED_W = 4;
    localparam logic [3:0] PANIC_BASE = 4'h5;
    localparam logic [3:0] HIGH_BASE = 4'h3;
    localparam logic [3:0] LOW_BASE = 4'h1;
    localparam real INTERVAL_NS = 7800.0;
    localparam real CLK_NS = 4.0;
    localparam int INTERVAL_CYC = int'(INTERVAL_NS / CLK_NS - 0.5);
    typedef enum {RC_IDLE, RC_WAIT, RC_GRANT} drs_rcomp_type;
endpackage

// file: hw/drs_tick_if.sv
// Carries the interval timer controls and its tick between the scheduler and its timer.
// Assumes both ends share sys_clk.
`timescale 1ns/100ps
interface drs_tick_if;
    logic run;
    logic [13:0] reload;
    logic tick;
    modport ctrl (output run, output reload, input tick);
    modport timer (input run, input reload, output tick);
endinterface

// file: hw/drs_interval_timer.sv
// Interval timer that pulses once every programmed number of memory clocks.
// Assumes the reload value is held steady by the register block.
`timescale 1ns/100ps
module drs_interval_timer (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Controls and tick.
    drs_tick_if.timer tickIf
);
    import drs_pkg::*;
    logic [INTV_W-1:0] count_r;
    logic [INTV_W-1:0] count_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        count_nxt = count_r;
        tick_nxt = 1'b0;
        if (!tickIf.run) begin
            count_nxt = '0;
        end else if (count_r + 14'h1 >= tickIf.reload) begin
            count_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            count_nxt = count_r + 14'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count_r <= '0;
            tick_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tickIf.tick = tick_r;
endmodule

// file: hw/drs_refresh_sched.sv
// Refresh scheduler for one memory channel: control register, owed count, watermarks, rcomp.
// Assumes the command scheduler pulses refreshDone once per refresh it issues.
// Operation
// - A tick is made every programmed interval count of memory clocks, meant to give 7.8 us.
// - The refresh gate bit makes refresh run normally whatever the counter enable says.
// - While the refresh gate is set the owed counter always runs.
// - With the gate clear and counter enable set, owed refreshes accumulate outside self-refresh.
// - With both bits clear nothing accumulates and no refresh is asked.
// - The style bit selects all ranks together when clear and independent ranks when set.
// - A count above the panic level raises the panic flag, and asks for refresh while the gate is set.
// - A count above the high level raises the high flag; refresh is asked only when it is also above the low level and the gate is set.
// - A count above the low level raises the low flag, and asks for refresh while the gate is set.
// - In independent mode a direct rcomp waits the wait ticks plus the direct quiet window.
// - In independent mode an indirect rcomp waits the wait ticks plus the indirect window.
`timescale 1ns/100ps
module drs_refresh_sched (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Register port.
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [11:0] regAddr,
    input wire logic [drs_pkg::REG_BYTES-1:0] regByteEn,
    input wire logic [drs_pkg::REG_W-1:0] regWrData,
    output logic [drs_pkg::REG_W-1:0] regRdData,
    output logic regRdValid,
    // Scheduler side.
    input wire logic selfRefresh,
    input wire logic refreshDone,
    input wire logic rcompDirectReq,
    input wire logic rcompIndirectReq,
    output logic refreshReq,
    output logic panicFlag,
    output logic highFlag,
    output logic lowFlag,
    output logic [drs_pkg::OWED_W-1:0] owedCount,
    output logic rankIndependent,
    output logic ddrSetupComplete,
    output logic rcompGrant
);
    import drs_pkg::*;

    function automatic logic [3:0] levelOf(input logic [1:0] code, input logic [3:0] base);
        levelOf = base + {2'b00, code};
    endfunction

    logic [REG_W-1:0] ctrl_r;
    logic [REG_W-1:0] ctrl_nxt;
    logic [REG_W-1:0] rd_r;
    logic [REG_W-1:0] rd_nxt;
    logic rdv_r;
    logic rdv_nxt;
    logic [REG_W-1:0] wrMask;
    logic hit;

    // Byte enables widen to a bit mask, and read-only bits are kept out.
    always_comb begin
        wrMask = '0;
        for (int i = 0; i < REG_BYTES; i++) begin
            wrMask[i*8 +: 8] = {8{regByteEn[i]}};
        end
        wrMask = wrMask & REG_WMASK;
        hit = (regAddr == REG_OFFSET);
        ctrl_nxt = ctrl_r;
        if (regWrEn && hit) begin
            ctrl_nxt = (ctrl_r & ~wrMask) | (regWrData & wrMask);
        end
        rdv_nxt = regRdEn;
        rd_nxt = (regRdEn && hit) ? ctrl_r : '0;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_r <= REG_RESET;
            rd_r <= '0;
            rdv_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rd_r <= rd_nxt;
            rdv_r <= rdv_nxt;
        end
    end

    logic gate;
    logic cntEn;
    logic running;
    assign gate = ctrl_r[GATE_BIT];
    assign cntEn = ctrl_r[CNTEN_BIT];
    assign running = gate | (cntEn & ~selfRefresh);

    drs_tick_if tickIf ();
    assign tickIf.run = running;
    assign tickIf.reload = ctrl_r[INTV_LSB +: INTV_W];

    drs_interval_timer u_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .tickIf(tickIf)
    );

    logic [OWED_W-1:0] owed_r;
    logic [OWED_W-1:0] owed_nxt;
    logic panic_r, high_r, low_r, req_r;
    logic panic_nxt, high_nxt, low_nxt, req_nxt;
    logic inc;
    logic dec;
    logic [3:0] panicLvl, highLvl, lowLvl;

    always_comb begin
        panicLvl = levelOf(ctrl_r[PANIC_LSB +: 2], PANIC_BASE);
        highLvl = levelOf(ctrl_r[HIGH_LSB +: 2], HIGH_BASE);
        lowLvl = levelOf(ctrl_r[LOW_LSB +: 2], LOW_BASE);
        inc = tickIf.tick && running && (owed_r != '1);
        dec = refreshDone && (owed_r != '0);
        owed_nxt = owed_r;
        if (inc && !dec) begin
            owed_nxt = owed_r + 4'h1;
        end else if (dec && !inc) begin
            owed_nxt = owed_r - 4'h1;
        end
        panic_nxt = owed_nxt > panicLvl;
        high_nxt = owed_nxt > highLvl;
        low_nxt = owed_nxt > lowLvl;
        req_nxt = gate && low_nxt;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            owed_r <= '0;
            panic_r <= 1'b0;
            high_r <= 1'b0;
            low_r <= 1'b0;
            req_r <= 1'b0;
        end else begin
            owed_r <= owed_nxt;
            panic_r <= panic_nxt;
            high_r <= high_nxt;
            low_r <= low_nxt;
            req_r <= req_nxt;
        end
    end

    drs_rcomp_type rc_r;
    drs_rcomp_type rc_nxt;
    logic [WIN_W:0] wait_r;
    logic [WIN_W:0] wait_nxt;
    logic grant_r;
    logic grant_nxt;
    logic style;
    assign style = ctrl_r[STYLE_BIT];

    always_comb begin
        rc_nxt = rc_r;
        wait_nxt = wait_r;
        case (rc_r)
            RC_IDLE: begin
                if (rcompDirectReq || rcompIndirectReq) begin
                    if (!style) begin
                        rc_nxt = RC_GRANT;
                    end else begin
                        rc_nxt = RC_WAIT;
                        wait_nxt = {1'b0, ctrl_r[WAIT_LSB +: WIN_W]} + (rcompDirectReq ?
                            {1'b0, ctrl_r[DIRQ_LSB +: WIN_W]} :
                            {1'b0, ctrl_r[INDQ_LSB +: WIN_W]});
                    end
                end
            end
            RC_WAIT: begin
                if (wait_r == '0) begin
                    rc_nxt = RC_GRANT;
                end else if (tickIf.tick) begin
                    wait_nxt = wait_r - 6'h1;
                end
            end
            RC_GRANT: rc_nxt = RC_IDLE;
            default: rc_nxt = RC_IDLE;
        endcase
        // The grant pulse is registered so that the output comes from a flop.
        grant_nxt = (rc_nxt == RC_GRANT);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rc_r <= RC_IDLE;
            wait_r <= '0;
            grant_r <= 1'b0;
        end else begin
            rc_r <= rc_nxt;
            wait_r <= wait_nxt;
            grant_r <= grant_nxt;
        end
    end

    assign regRdData = rd_r;
    assign regRdValid = rdv_r;
    assign refreshReq = req_r;
    assign panicFlag = panic_r;
    assign highFlag = high_r;
    assign lowFlag = low_r;
    assign owedCount = owed_r;
    assign rankIndependent = ctrl_r[STYLE_BIT];
    assign ddrSetupComplete = ctrl_r[DONE_BIT];
    assign rcompGrant = grant_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_tickIdle;
        !running [*2];
    endsequence

    a_idle_no_count: assert property (s_tickIdle |=> !inc)
        else $error("owed count grew while stopped");
    a_gate_runs: assert property ((gate && tickIf.tick && owed_r != '1 && !refreshDone)
        |=> owedCount == $past(owedCount) + 4'h1)
        else $error("tick lost with gate set");
    a_selfref_stops: assert property ((!gate && selfRefresh)
        |=> !(owedCount > $past(owedCount)))
        else $error("count grew in self-refresh");
    a_req_needs_gate: assert property (refreshReq |-> $past(gate))
        else $error("refresh asked without gate");
    a_panic_level: assert property (panicFlag == (owedCount > $past(panicLvl)))
        else $error("panic flag wrong");
    a_high_level: assert property (highFlag == (owedCount > $past(highLvl)))
        else $error("high flag wrong");
    a_low_level: assert property (lowFlag == (owedCount > $past(lowLvl)))
        else $error("low flag wrong");
    a_tick_adds: assert property ((inc && !dec) |=> owedCount == $past(owedCount) + 4'h1)
        else $error("tick did not add");
    a_shared_fast: assert property ((rc_r == RC_IDLE && rcompDirectReq && !style)
        |=> rcompGrant)
        else $error("all-rank rcomp not granted at once");
    a_wait_holds: assert property ((rc_r == RC_WAIT && wait_r != '0) |=> !rcompGrant)
        else $error("rcomp granted before its window");
    a_timer_period: assert property ((tickIf.tick && tickIf.reload == 14'h3 && running)
        ##1 (running && $stable(tickIf.reload)) [*3] |-> tickIf.tick)
        else $error("tick period wrong");
endmodule

// file: test/drs_sched_model.sv
// Command scheduler model that issues refreshes one at a time while serve and refreshReq are high.
// Assumes sys_clk and srst are shared with the refresh scheduler.
`timescale 1ns/100ps
module drs_sched_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Bench controls.
    input wire logic serve,
    input wire logic [2:0] lat,
    // Refresh handshake.
    input wire logic refreshReq,
    output logic refreshDone
);
    logic [3:0] busy_r;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_r <= 4'h0;
            refreshDone <= 1'h0;
        end else begin
            refreshDone <= (busy_r == 4'h1);
            if (busy_r != 4'h0) begin
                busy_r <= busy_r - 4'h1;
            end else if (serve && refreshReq && !refreshDone) begin
                busy_r <= {1'h0, lat} + 4'h2;
            end
        end
    end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the refresh scheduler.
// Assumes drs_sched_model stands in for the command scheduler.
`timescale 1ns/100ps
module tb_top;
    import drs_pkg::*;
    logic sys_clk = 1'h0, srst = 1'h1, regWrEn = 1'h0, regRdEn = 1'h0, selfRefresh = 1'h0;
    logic rcompDirectReq = 1'h0, rcompIndirectReq = 1'h0, serve = 1'h0;
    logic [11:0] regAddr = 12'h269;
    logic [5:0] regByteEn = 6'h3f;
    logic [47:0] regWrData = 48'h0, regRdData;
    logic [2:0] lat = 3'h0;
    logic regRdValid, refreshDone, refreshReq, panicFlag, highFlag, lowFlag;
    logic rankIndependent, ddrSetupComplete, rcompGrant;
    logic [3:0] owedCount;
    logic [4:0] wt = 5'h6, dq = 5'h10, iq = 5'h18;
    logic [1:0] p, h, l;
    logic [47:0] expQ[$];
    int miscompares = 0, cmp_count = 0, seed = 32'h619c, n;
    drs_refresh_sched i_drs_refresh_sched (.sys_clk, .srst, .regWrEn, .regRdEn, .regAddr,
        .regByteEn, .regWrData, .regRdData, .regRdValid, .selfRefresh, .refreshDone,
        .rcompDirectReq, .rcompIndirectReq, .refreshReq, .panicFlag, .highFlag, .lowFlag,
        .owedCount, .rankIndependent, .ddrSetupComplete, .rcompGrant);
    drs_sched_model i_drs_sched_model (.sys_clk, .srst, .serve, .lat, .refreshReq,
        .refreshDone);
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [47:0] cw(input logic g, input logic e, input logic s,
            input logic [1:0] pp, input logic [1:0] hh, input logic [1:0] ll,
            input logic [13:0] t);
        return {6'h0, dq, iq, wt, 1'h0, e, s, g, 1'h1, 2'h0, pp, hh, ll, t};
    endfunction
    task automatic wr(input logic [47:0] d);
        @(posedge sys_clk);
        regWrEn <= 1'h1;
        regWrData <= d;
        @(posedge sys_clk);
        regWrEn <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [47:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'h1;
        expQ.push_back(exp);
        @(posedge sys_clk);
        regRdEn <= 1'h0;
        regAddr <= 12'h269;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic waitChg(output int k);
        logic [3:0] c;
        c = owedCount;
        k = 0;
        while (owedCount === c && k < 200) begin
            @(posedge sys_clk);
            k++;
        end
    endtask
    task automatic rc(input logic dir, input int w);
        @(posedge sys_clk);
        rcompDirectReq <= dir;
        rcompIndirectReq <= !dir;
        @(posedge sys_clk);
        rcompDirectReq <= 1'h0;
        rcompIndirectReq <= 1'h0;
        n = 0;
        while (rcompGrant !== 1'h1 && n < 500) begin
            @(posedge sys_clk);
            n++;
        end
        // One tick every three cycles, plus up to two cycles of tick phase.
        check(n >= w * 3 && n <= w * 3 + 2, 1'h1);
    endtask
    // Read data is compared in order against the noted expectations.
    always @(negedge sys_clk) begin
        if (regRdValid) begin
            check(regRdData, expQ.pop_front());
        end
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        conclude();
    end
    initial begin
        idle(20);
        srst <= 1'h0;
        rd(12'h269, REG_RESET);
        check(ddrSetupComplete, 1'h0);
        check(rankIndependent, 1'h0);
        rd(12'h26a, 48'h0);
        wr(48'hffffffffffff);
        rd(12'h269, REG_WMASK);
        check(ddrSetupComplete, 1'h1);
        check(rankIndependent, 1'h1);
        regByteEn <= 6'h01;
        wr(48'h0);
        regByteEn <= 6'h3f;
        rd(12'h269, REG_WMASK & 48'hffffffffff00);
        wr(cw(0, 0, 0, 0, 0, 0, 14'h5));
        idle(30);
        check(owedCount, 4'h0);
        selfRefresh <= 1'h1;
        wr(cw(0, 1, 0, 0, 0, 0, 14'h5));
        rd(12'h269, cw(0, 1, 0, 0, 0, 0, 14'h5));
        idle(30);
        check(owedCount, 4'h0);
        selfRefresh <= 1'h0;
        waitChg(n);
        waitChg(n);
        check(n, 5);
        n = 0;
        while (owedCount !== 4'h6 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        selfRefresh <= 1'h1;
        check(refreshReq, 1'h0);
        repeat (4) begin
            {p, h, l} = $random(seed);
            wr(cw(0, 1, 0, p, h, l, 14'h5));
            idle(3);
            check(panicFlag, 6 > 5 + p);
            check(highFlag, 6 > 3 + h);
            check(lowFlag, 6 > 1 + l);
        end
        wr(cw(1, 0, 0, 0, 0, 0, 14'h3));
        idle(3);
        check(refreshReq, 1'h1);
        idle(60);
        check(owedCount, 4'hf);
        lat <= 3'($random(seed));
        serve <= 1'h1;
        wr(cw(1, 0, 0, 0, 0, 0, 14'h20));
        n = 0;
        while (owedCount > 4'h1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        check(n < 2000, 1'h1);
        check(lowFlag, 1'h0);
        check(refreshReq, 1'h0);
        serve <= 1'h0;
        @(posedge sys_clk);
        rcompDirectReq <= 1'h1;
        @(posedge sys_clk);
        rcompDirectReq <= 1'h0;
        @(posedge sys_clk);
        check(rcompGrant, 1'h1);
        {wt, dq, iq} = $random(seed);
        wr(cw(1, 0, 1, 0, 0, 0, 14'h3));
        rc(1'h1, wt + dq);
        rc(1'h0, wt + iq);
        idle(60);
        check(owedCount, 4'hf);
        // A reset in mid-run must clear the owed count, flags and register.
        srst <= 1'h1;
        idle(2);
        srst <= 1'h0;
        @(posedge sys_clk);
        check(owedCount, 4'h0);
        check(lowFlag, 1'h0);
        check(rcompGrant, 1'h0);
        rd(12'h269, REG_RESET);
        idle(5);
        check(expQ.size(), 0);
        conclude();
    end
endmodule
